// [tb/bus_master_model.sv]
// Two-wire bus master model, 125 ns clock, still between frames.
// Assumes a pull-up resolves the data line outside this model.
`timescale 1ns/1ns
module bus_master_model (
    // Bus lines
    output reg  scl,
    output reg  sda_drv,
    input  wire sda
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task bit_io(input b, output r);
        begin
            #20 sda_drv = b;
            #40 scl = 1'b1;
            #55 r = sda;
            #10 scl = 1'b0;
        end
    endtask
    task start;
        begin
            #30 sda_drv = 1'b1;
            #30 scl = 1'b1;
            #40 sda_drv = 1'b0;
            #40 scl = 1'b0;
        end
    endtask
    task stop;
        begin
            #30 sda_drv = 1'b0;
            #30 scl = 1'b1;
            #40 sda_drv = 1'b1;
            #40;
        end
    endtask
    // Byte out, most significant bit first
    task wbyte(input [7:0] b, output ack);
        integer i;
        reg     r;
        begin
            for (i = 7; i >= 0; i = i - 1)
                bit_io(b[i], r);
            bit_io(1'b1, r);
            ack = ~r;
        end
    endtask
    // Byte in; no acknowledge on the last one
    task rbyte(output [7:0] d, input last);
        integer i;
        reg     r;
        begin
            for (i = 7; i >= 0; i = i - 1)
                bit_io(1'b1, d[i]);
            bit_io(last, r);
        end
    endtask
endmodule

// [tb/cfg_port_properties.sv]
// Checker for the configuration port, bound to its top module.
// Assumes select pins stay still across each startup.
`timescale 1ns/1ns
module cfg_port_properties #(
    parameter [31:0] POR_CYCLES = 32'd50
) (
    // Clock and reset
    input wire       core_clk,
    input wire       rst,
    // Two-wire bus
    input wire       scl_in,
    input wire       sda_in,
    input wire       sda_out_r,
    input wire       sda_oe_r,
    // Select pins
    input wire       config_select_high,
    input wire       config_select_low,
    // Status
    input wire       cfg_done_r,
    input wire       busy_r,
    input wire       div_sync_r,
    input wire [1:0] cfg_sel_r,
    input wire       addr_sel_r
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // ----------------
    // Startup cycle count
    // ----------------
    reg [31:0] por_cnt_r;
    always @(posedge core_clk) begin
        if (rst)
            por_cnt_r <= 32'h0;
        else if (!cfg_done_r)
            por_cnt_r <= por_cnt_r + 32'h1;
    end

    // ----------------
    // Properties
    // ----------------
    property p_por_len;
        $rose(cfg_done_r) |-> (por_cnt_r >= POR_CYCLES)
            && (por_cnt_r < POR_CYCLES + 32'h200);
    endproperty
    a_por_len: assert property (p_por_len)
        else $error("bad startup length");
    property p_reset_state;
        $fell(rst) |-> busy_r && !cfg_done_r && !sda_oe_r;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("bad reset state");
    property p_sync_start;
        $rose(cfg_done_r) |-> ##[0:1] div_sync_r;
    endproperty
    a_sync_start: assert property (p_sync_start)
        else $error("no sync");
    property p_sync_once;
        div_sync_r |-> cfg_done_r ##1 !div_sync_r;
    endproperty
    a_sync_once: assert property (p_sync_once)
        else $error("sync too long");
    property p_busy_fall;
        $rose(cfg_done_r) |-> ##[1:2] !busy_r;
    endproperty
    a_busy_fall: assert property (p_busy_fall)
        else $error("still busy");
    property p_quiet_busy;
        busy_r && $past(busy_r) |-> !sda_oe_r;
    endproperty
    a_quiet_busy: assert property (p_quiet_busy)
        else $error("busy drive");
    property p_done_hold;
        cfg_done_r |=> cfg_done_r;
    endproperty
    a_done_hold: assert property (p_done_hold)
        else $error("done dropped");
    property p_sel_stable;
        cfg_done_r |=> $stable(cfg_sel_r);
    endproperty
    a_sel_stable: assert property (p_sel_stable)
        else $error("bank moved");
    property p_sel_pins;
        $rose(cfg_done_r) |->
            cfg_sel_r == {config_select_high, config_select_low};
    endproperty
    a_sel_pins: assert property (p_sel_pins)
        else $error("bank not pins");
    property p_no_early_ack;
        !cfg_done_r |-> !sda_oe_r;
    endproperty
    a_no_early_ack: assert property (p_no_early_ack)
        else $error("early drive");
    property p_out_low;
        sda_oe_r |-> !sda_out_r;
    endproperty
    a_out_low: assert property (p_out_low)
        else $error("drive high");

    c_startup: cover property ($rose(cfg_done_r));
    c_ack: cover property ($rose(sda_oe_r));
    c_addr_alt: cover property ($rose(addr_sel_r));
    c_commit: cover property (cfg_done_r && $fell(busy_r));
endmodule

bind cfg_port cfg_port_properties #(.POR_CYCLES(POR_CYCLES))
    cfg_port_properties_i (
    .core_clk(core_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out_r(sda_out_r), .sda_oe_r(sda_oe_r),
    .config_select_high(config_select_high),
    .config_select_low(config_select_low), .cfg_done_r(cfg_done_r),
    .busy_r(busy_r), .div_sync_r(div_sync_r), .cfg_sel_r(cfg_sel_r),
    .addr_sel_r(addr_sel_r)
);

// [tb/test_clock_buffer_config_port.sv]
// Self-checking bench for the configuration port.
// Assumes the master model and the bound checker are compiled alongside.
`timescale 1ns/1ns
module test_clock_buffer_config_port;
    // Clock, reset, pins
    reg        core_clk = 1'b0;
    reg        rst = 1'b1;
    reg        sel_hi = 1'b1;
    reg        sel_lo = 1'b0;
    // Bus and status
    wire       scl;
    wire       sda_drv;
    wire       sda_out_r;
    wire       sda_oe_r;
    wire       cfg_done_r;
    wire       busy_r;
    wire       div_sync_r;
    wire       addr_sel_r;
    wire [1:0] cfg_sel_r;
    wire       sda = sda_drv & ~(sda_oe_r & ~sda_out_r);
    integer    errors = 0;
    integer    n_tests = 0;
    reg        ack;
    reg  [7:0] d;

    always #5 core_clk = ~core_clk;
    cfg_port #(.POR_CYCLES(32'd50)) cfg_port_i (
        .core_clk(core_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
        .sda_out_r(sda_out_r), .sda_oe_r(sda_oe_r),
        .config_select_high(sel_hi), .config_select_low(sel_lo),
        .cfg_done_r(cfg_done_r), .busy_r(busy_r),
        .div_sync_r(div_sync_r), .cfg_sel_r(cfg_sel_r),
        .addr_sel_r(addr_sel_r)
    );
    bus_master_model bus_master_model_i (
        .scl(scl), .sda_drv(sda_drv), .sda(sda)
    );

    // ----------------
    // Shared tasks
    // ----------------
    task check(input string what, input logic [7:0] seen,
               input logic [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("Error %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task results;
        begin
            $display("Counts: %0d errors, %0d checks", errors, n_tests);
            if (errors == 0 && n_tests > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task wait_idle;
        integer i;
        begin
            i = 0;
            @(posedge core_clk);
            while (busy_r !== 1'b0 && i < 5000) begin
                @(posedge core_clk);
                i = i + 1;
            end
            check("idle", {7'h0, busy_r}, 8'h00);
        end
    endtask
    task do_reset;
        begin
            @(posedge core_clk);
            rst <= 1'b1;
            repeat (3) @(posedge core_clk);
            rst <= 1'b0;
            @(posedge core_clk);
            #1;
            check("busy_por", {7'h0, busy_r}, 8'h01);
            wait_idle();
        end
    endtask
    task tx(input [7:0] b, input logic exp_ack);
        begin
            bus_master_model_i.wbyte(b, ack);
            check("ack", {7'h0, ack}, {7'h0, exp_ack});
        end
    endtask
    task ptr(input [7:0] p);
        begin
            tx(8'hD4, 1'b1);
            tx(8'h00, 1'b1);
            tx(p, 1'b1);
        end
    endtask
    task wr(input [7:0] p, input [23:0] dat, input integer n);
        integer i;
        begin
            bus_master_model_i.start();
            ptr(p);
            for (i = 0; i < n; i = i + 1)
                tx(dat[23 - 8 * i -: 8], 1'b1);
            bus_master_model_i.stop();
            #60;
            check("busy_commit", {7'h0, busy_r}, 8'h01);
            wait_idle();
        end
    endtask
    task rd(input [7:0] p, input [23:0] exp, input integer n);
        integer i;
        begin
            bus_master_model_i.start();
            ptr(p);
            bus_master_model_i.start();
            tx(8'hD5, 1'b1);
            for (i = 0; i < n; i = i + 1) begin
                bus_master_model_i.rbyte(d, i == n - 1);
                check("rdata", d, exp[23 - 8 * i -: 8]);
            end
            bus_master_model_i.stop();
            wait_idle();
        end
    endtask

    // ----------------
    // Scenarios
    // ----------------
    task t_startup;
        begin
            check("cfg_sel", {6'h0, cfg_sel_r}, 8'h02);
            check("done", {7'h0, cfg_done_r}, 8'h01);
            check("addr_sel", {7'h0, addr_sel_r}, 8'h00);
        end
    endtask
    task t_addr;
        begin
            bus_master_model_i.start();
            tx(8'hD0, 1'b0);
            bus_master_model_i.stop();
            bus_master_model_i.start();
            tx(8'hD4, 1'b1);
            bus_master_model_i.stop();
            wait_idle();
        end
    endtask
    task t_block;
        begin
            wr(8'h10, 24'h3CC381, 3);
            rd(8'h11, 24'hC38100, 2);
            rd(8'h10, 24'h3C0000, 1);
        end
    endtask
    task t_stage;
        begin
            bus_master_model_i.start();
            ptr(8'h20);
            tx(8'hA5, 1'b1);
            bus_master_model_i.start();
            ptr(8'h20);
            bus_master_model_i.start();
            tx(8'hD5, 1'b1);
            bus_master_model_i.rbyte(d, 1'b1);
            check("staged", d, 8'h00);
            bus_master_model_i.stop();
            wait_idle();
            rd(8'h20, 24'hA50000, 1);
        end
    endtask
    task t_addr_sel;
        begin
            wr(8'h00, 24'h010000, 1);
            check("addr_sel", {7'h0, addr_sel_r}, 8'h01);
            bus_master_model_i.start();
            tx(8'hD4, 1'b0);
            bus_master_model_i.stop();
            bus_master_model_i.start();
            tx(8'hD0, 1'b1);
            bus_master_model_i.stop();
            do_reset();
            check("addr_sel_rst", {7'h0, addr_sel_r}, 8'h00);
            rd(8'h20, 24'h000000, 1);
        end
    endtask
    task t_save;
        begin
            wr(8'h30, 24'h5C0000, 1);
            wr(8'h72, 24'h080000, 1);
            do_reset();
            rd(8'h30, 24'h5C0000, 1);
            wr(8'h30, 24'h110000, 1);
            wr(8'h72, 24'h010000, 1);
            rd(8'h30, 24'h5C0000, 1);
        end
    endtask

    initial begin
        do_reset();
        t_startup();
        t_addr();
        t_block();
        t_stage();
        t_addr_sel();
        t_save();
        results();
    end
    initial begin
        #500000;
        errors = errors + 1;
        results();
    end
endmodule

// [verilog/cfg_mem.v]
// Byte memory with one write port and a registered read port.
// Assumes contents start at zero; no reset on the array.
`timescale 1ns/1ns
module cfg_mem #(
    parameter AW    = 7,
    parameter DEPTH = 128
) (
    // Clock
    input  wire          clk,
    // Write port
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [7:0]    wdata,
    // Read port
    input  wire [AW-1:0] raddr,
    output reg  [7:0]    rdata
);
    reg [7:0] mem [0:DEPTH-1];
    integer i;

    initial begin
        for (i = 0; i < DEPTH; i = i + 1) begin
            mem[i] = 8'h00;
        end
        rdata = 8'h00;
    end

    always @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// [verilog/cfg_port.v]
// Configuration port of a programmable clock buffer: power-on reset,
// startup load from stored configurations, two-wire slave port.
// Assumes SCL and SDA pins and select pins are asynchronous to core_clk.
`timescale 1ns/1ns
`include "cfg_port_defs.vh"
module cfg_port #(
    parameter [31:0] POR_CYCLES = `POR_MAX_MS * `CLK_FREQ_KHZ
) (
    // Clock and reset
    input  wire       core_clk,
    input  wire       rst,
    // Two-wire bus
    input  wire       scl_in,
    input  wire       sda_in,
    output reg        sda_out_r,
    output reg        sda_oe_r,
    // Configuration select pins
    input  wire       config_select_high,
    input  wire       config_select_low,
    // Status
    output reg        cfg_done_r,
    output reg        busy_r,
    output reg        div_sync_r,
    output reg  [1:0] cfg_sel_r,
    output reg        addr_sel_r
);
    // ----------------
    // States
    // ----------------
    localparam [5:0] C_POR    = 6'h01;
    localparam [5:0] C_LOAD   = 6'h02;
    localparam [5:0] C_RUN    = 6'h04;
    localparam [5:0] C_COMMIT = 6'h08;
    localparam [5:0] C_SAVE   = 6'h10;
    localparam [5:0] C_REST   = 6'h20;

    localparam [4:0] S_IDLE = 5'h01;
    localparam [4:0] S_RX   = 5'h02;
    localparam [4:0] S_ACK  = 5'h04;
    localparam [4:0] S_TX   = 5'h08;
    localparam [4:0] S_MACK = 5'h10;

    localparam [3:0] P_DEV  = 4'h1;
    localparam [3:0] P_ADRH = 4'h2;
    localparam [3:0] P_ADRL = 4'h4;
    localparam [3:0] P_DATA = 4'h8;

    localparam [23:0] POR_LAST = POR_CYCLES[23:0] - 24'h000001;

    // Bus address in use
    function [6:0] slave_addr;
        input sel;
        begin
            slave_addr = sel ? `SLAVE_ADDR_ALT : `SLAVE_ADDR_DEF;
        end
    endfunction

    // ----------------
    // Pin synchronisers and edge detect
    // ----------------
    wire [3:0] pins_s;
    wire       scl_s;
    wire       sda_s;
    reg        scl_d_r;
    reg        sda_d_r;

    sync2 #(.W(4)) u_sync (
        .clk (core_clk),
        .rst (rst),
        .d   ({config_select_high, config_select_low, sda_in, scl_in}),
        .q   (pins_s)
    );
    assign scl_s = pins_s[0];
    assign sda_s = pins_s[1];

    always @(posedge core_clk) begin
        if (rst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    wire scl_rise  = scl_s & ~scl_d_r;
    wire scl_fall  = ~scl_s & scl_d_r;
    wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // ----------------
    // Declarations
    // ----------------
    reg  [5:0]   ctl_r;
    reg  [23:0]  por_cnt_r;
    reg  [7:0]   walk_idx_r;
    reg          wr_v_r;
    reg  [6:0]   wr_idx_r;
    reg          pend_sel_r;
    reg          pend_save_r;
    reg          pend_rest_r;
    reg  [127:0] dirty_r;
    reg  [4:0]   st_r;
    reg  [3:0]   phase_r;
    reg  [3:0]   bit_r;
    reg  [7:0]   sh_r;
    reg          rd_r;
    reg  [15:0]  ptr_r;
    reg          stg_we_r;
    reg  [6:0]   stg_addr_r;
    reg  [7:0]   stg_data_r;
    wire [7:0]   live_rdata;
    wire [7:0]   otp_rdata;
    wire [7:0]   stg_rdata;

    wire run      = ctl_r == C_RUN;
    wire commit   = ctl_r == C_COMMIT;
    wire saving   = ctl_r == C_SAVE;
    wire loading  = (ctl_r == C_LOAD) | (ctl_r == C_REST);
    wire walking  = loading | commit | saving;
    wire walk_end = wr_v_r & (wr_idx_r == `REG_LAST);

    // ----------------
    // Memories: live registers, staging buffer, stored configurations
    // ----------------
    wire       live_we    = wr_v_r & (loading |
                            (commit & dirty_r[wr_idx_r]));      // [R7]
    wire [7:0] live_wdata = commit ? stg_rdata : otp_rdata;
    wire [6:0] live_raddr = saving ? walk_idx_r[6:0] : ptr_r[6:0];

    cfg_mem #(.AW(`REG_AW), .DEPTH(`REG_DEPTH)) u_live (
        .clk   (core_clk),
        .we    (live_we),
        .waddr (wr_idx_r),
        .wdata (live_wdata),
        .raddr (live_raddr),
        .rdata (live_rdata)
    );

    cfg_mem #(.AW(`REG_AW), .DEPTH(`REG_DEPTH)) u_stage (
        .clk   (core_clk),
        .we    (stg_we_r),
        .waddr (stg_addr_r),
        .wdata (stg_data_r),
        .raddr (walk_idx_r[6:0]),
        .rdata (stg_rdata)
    );

    // Four banks, bank chosen by the sampled select pins [R11] [R18]
    cfg_mem #(.AW(`OTP_AW), .DEPTH(`OTP_DEPTH)) u_otp (
        .clk   (core_clk),
        .we    (saving & wr_v_r),                               // [R15]
        .waddr ({cfg_sel_r, wr_idx_r}),
        .wdata (live_rdata),
        .raddr ({cfg_sel_r, walk_idx_r[6:0]}),
        .rdata (otp_rdata)
    );

    // ----------------
    // Control sequence: reset, load, run, commit, save, restore
    // ----------------
    always @(posedge core_clk) begin
        if (rst) begin
            ctl_r       <= C_POR;                               // [R13]
            por_cnt_r   <= 24'h000000;
            walk_idx_r  <= 8'h00;
            wr_v_r      <= 1'b0;
            wr_idx_r    <= 7'h00;
            pend_sel_r  <= 1'b0;
            pend_save_r <= 1'b0;
            pend_rest_r <= 1'b0;
            cfg_done_r  <= 1'b0;
            busy_r      <= 1'b1;
            div_sync_r  <= 1'b0;
            cfg_sel_r   <= 2'h0;
            addr_sel_r  <= 1'b0;
        end else begin
            div_sync_r <= 1'b0;
            busy_r     <= ~run;
            if (walking & ~walk_idx_r[7]) begin
                wr_v_r     <= 1'b1;
                wr_idx_r   <= walk_idx_r[6:0];
                walk_idx_r <= walk_idx_r + 8'h01;
            end else begin
                wr_v_r <= 1'b0;
            end
            if (live_we & (wr_idx_r == `ADDR_SEL_REG)) begin
                pend_sel_r <= live_wdata[`ADDR_SEL_BIT];        // [R17]
            end
            if (live_we & commit & (wr_idx_r == `CMD_REG)) begin
                pend_save_r <= live_wdata[`CMD_SAVE_BIT];       // [R15]
                pend_rest_r <= live_wdata[`CMD_RESTORE_BIT];
            end
            case (ctl_r)
                C_POR: begin
                    por_cnt_r <= por_cnt_r + 24'h000001;
                    if (por_cnt_r == POR_LAST) begin            // [R8]
                        ctl_r      <= C_LOAD;                   // [R9]
                        cfg_sel_r  <= pins_s[3:2];              // [R18]
                        walk_idx_r <= 8'h00;
                        pend_sel_r <= 1'b0;
                    end
                end
                C_LOAD: begin
                    if (walk_end) begin
                        ctl_r      <= C_RUN;                    // [R10]
                        cfg_done_r <= 1'b1;
                        div_sync_r <= 1'b1;                     // [R14]
                        addr_sel_r <= pend_sel_r;
                    end
                end
                C_RUN: begin
                    walk_idx_r  <= 8'h00;
                    pend_sel_r  <= addr_sel_r;
                    pend_save_r <= 1'b0;
                    pend_rest_r <= 1'b0;
                    if (stop_det & (|dirty_r)) begin
                        ctl_r <= C_COMMIT;                      // [R7]
                    end
                end
                C_COMMIT: begin
                    if (walk_end) begin
                        addr_sel_r <= pend_sel_r;               // [R12]
                        walk_idx_r <= 8'h00;
                        if (pend_save_r) begin
                            ctl_r <= C_SAVE;                    // [R16]
                        end else if (pend_rest_r) begin
                            ctl_r <= C_REST;                    // [R16]
                        end else begin
                            ctl_r <= C_RUN;
                        end
                    end
                end
                C_SAVE: begin
                    if (walk_end) begin
                        ctl_r <= C_RUN;
                    end
                end
                C_REST: begin
                    if (walk_end) begin
                        ctl_r      <= C_RUN;
                        addr_sel_r <= pend_sel_r;               // [R15]
                    end
                end
                default: begin
                    ctl_r <= C_POR;
                end
            endcase
        end
    end

    // ----------------
    // Staging dirty marks
    // ----------------
    always @(posedge core_clk) begin
        if (rst) begin
            dirty_r <= 128'h0;
        end else if (commit & walk_end) begin
            dirty_r <= 128'h0;
        end else if (stg_we_r) begin
            dirty_r[stg_addr_r] <= 1'b1;                        // [R7]
        end
    end

    // ----------------
    // Two-wire slave engine
    // ----------------
    always @(posedge core_clk) begin
        if (rst | ~run) begin
            st_r       <= S_IDLE;                               // [R10] [R16]
            phase_r    <= P_DEV;
            bit_r      <= 4'h0;
            sh_r       <= 8'h00;
            rd_r       <= 1'b0;
            sda_oe_r   <= 1'b0;
            sda_out_r  <= 1'b0;
            stg_we_r   <= 1'b0;
            stg_addr_r <= 7'h00;
            stg_data_r <= 8'h00;
            if (rst) begin
                ptr_r <= 16'h0000;
            end
        end else begin
            stg_we_r <= 1'b0;
            if (start_det) begin
                st_r     <= S_RX;
                phase_r  <= P_DEV;
                bit_r    <= 4'h0;
                sda_oe_r <= 1'b0;
            end else if (stop_det) begin
                st_r     <= S_IDLE;                             // [R6]
                sda_oe_r <= 1'b0;
            end else begin
                case (st_r)
                    S_IDLE: begin
                        sda_oe_r <= 1'b0;
                    end
                    S_RX: begin
                        if (scl_rise) begin
                            sh_r  <= {sh_r[6:0], sda_s};        // [R5]
                            bit_r <= bit_r + 4'h1;
                        end else if (scl_fall & (bit_r == `BYTE_BITS)) begin
                            bit_r    <= 4'h0;
                            st_r     <= S_ACK;
                            sda_oe_r <= 1'b1;
                            case (phase_r)
                                P_DEV: begin
                                    if (sh_r[7:1] !=
                                        slave_addr(addr_sel_r)) begin
                                        st_r     <= S_IDLE;     // [R19]
                                        sda_oe_r <= 1'b0;
                                    end
                                    rd_r    <= sh_r[0];         // [R1] [R2]
                                    phase_r <= P_ADRH;
                                end
                                P_ADRH: begin
                                    ptr_r[15:8] <= sh_r;        // [R3]
                                    phase_r     <= P_ADRL;
                                end
                                P_ADRL: begin
                                    ptr_r[7:0] <= sh_r;         // [R3]
                                    phase_r    <= P_DATA;
                                end
                                P_DATA: begin
                                    stg_we_r   <= 1'b1;         // [R7]
                                    stg_addr_r <= ptr_r[6:0];
                                    stg_data_r <= sh_r;
                                    ptr_r      <= ptr_r + 16'h0001; // [R4]
                                end
                                default: begin
                                    phase_r <= P_DEV;
                                end
                            endcase
                        end
                    end
                    S_ACK: begin
                        if (scl_fall) begin
                            bit_r <= 4'h0;
                            if (rd_r) begin
                                st_r     <= S_TX;
                                sh_r     <= {live_rdata[6:0], 1'b1};
                                sda_oe_r <= ~live_rdata[7];     // [R5]
                            end else begin
                                st_r     <= S_RX;
                                sda_oe_r <= 1'b0;
                            end
                        end
                    end
                    S_TX: begin
                        if (scl_rise) begin
                            bit_r <= bit_r + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_r == `BYTE_BITS) begin
                                st_r     <= S_MACK;
                                sda_oe_r <= 1'b0;
                                ptr_r    <= ptr_r + 16'h0001;   // [R4]
                            end else begin
                                sda_oe_r <= ~sh_r[7];
                                sh_r     <= {sh_r[6:0], 1'b1};
                            end
                        end
                    end
                    S_MACK: begin
                        if (scl_rise) begin
                            st_r <= sda_s ? S_IDLE : S_ACK;     // [R6]
                        end
                    end
                    default: begin
                        st_r <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule

// [verilog/cfg_port_defs.vh]
// Constants for the clock buffer configuration port.
// Assumes a 100 MHz core clock and an 8-bit register byte array.
//
// How it works
// R1 - Answers at bus address 0xD0 or 0xD4
// R2 - Block writes and block reads, any length
// R3 - Two address bytes set first register position
// R4 - Pointer increments after each complete byte
// R5 - Bytes shifted most significant bit first
// R6 - Master may stop after any byte
// R7 - Writes staged, committed together at STOP
// R8 - Power-on reset lasts at most 10 ms
// R9 - After reset, registers load from stored configuration
// R10 - No bus answers until load completes
// R11 - Store holds four complete configurations
// R12 - Loaded registers writable after reset completes
// R13 - Unsaved written values lost on any reset
// R14 - Divider sync pulse at startup load
// R15 - Save bit stores, restore bit reloads
// R16 - Save or restore runs after STOP, no acks
// R17 - Address 0xD4 default, 0xD0 when bit set
// R18 - Select pins sampled at startup pick configuration
// R19 - Foreign bus addresses are never acknowledged
`ifndef CFG_PORT_DEFS_VH
`define CFG_PORT_DEFS_VH

// ----------------
// Timing
// ----------------
`define CLK_FREQ_KHZ     100000
`define POR_MAX_MS       10

// ----------------
// Register array and store
// ----------------
`define REG_AW           7
`define REG_DEPTH        128
`define CFG_COUNT        4
`define OTP_AW           9
`define OTP_DEPTH        512
`define REG_LAST         7'h7F
`define BYTE_BITS        4'h8

// ----------------
// Bus addresses and control fields
// ----------------
`define SLAVE_ADDR_DEF   7'h6A
`define SLAVE_ADDR_ALT   7'h68
`define ADDR_SEL_REG     7'h00
`define ADDR_SEL_BIT     0
`define CMD_REG          7'h72
`define CMD_SAVE_BIT     3
`define CMD_RESTORE_BIT  0

`endif

// [verilog/sync2.v]
// Two-stage synchroniser for asynchronous input levels.
// Assumes inputs change slowly against the sampling clock.
`timescale 1ns/1ns
module sync2 #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clk,
    input  wire         rst,
    // Levels
    input  wire [W-1:0] d,
    output wire [W-1:0] q
);
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : bit_sync
            reg meta_r;
            reg sync_r;
            always @(posedge clk) begin
                if (rst) begin
                    meta_r <= 1'b1;
                    sync_r <= 1'b1;
                end else begin
                    meta_r <= d[g];
                    sync_r <= meta_r;
                end
            end
            assign q[g] = sync_r;
        end
    endgenerate
endmodule
